// ==== include/mdu_pkg.sv ====
// Shared constants and types of the multiply/divide unit
`default_nettype none
package mdu_pkg;
  localparam int unsigned ACC_NUM = 4;
  localparam logic [63:0] ACC_RST = 64'h0;

  // Divider iteration counts and skips per dividend width class
  localparam logic [5:0] DIV_ITER_FULL = 6'h20;
  localparam logic [5:0] DIV_SKIP8     = 6'h17;
  localparam logic [5:0] DIV_SKIP16    = 6'h0F;
  localparam logic [5:0] DIV_SKIP24    = 6'h07;
  localparam logic [5:0] DIV_SKIP32    = 6'h00;

  // Divide latency in cycles, unsigned and signed
  localparam logic [5:0] DIV_LAT8_U  = 6'h0C;
  localparam logic [5:0] DIV_LAT16_U = 6'h14;
  localparam logic [5:0] DIV_LAT24_U = 6'h1C;
  localparam logic [5:0] DIV_LAT32_U = 6'h24;
  localparam logic [5:0] DIV_LAT8_S  = 6'h0E;
  localparam logic [5:0] DIV_LAT16_S = 6'h16;
  localparam logic [5:0] DIV_LAT24_S = 6'h1E;
  localparam logic [5:0] DIV_LAT32_S = 6'h26;

  // Fractional saturation bounds and the product that overflows when doubled
  localparam logic [63:0] SAT_POS  = 64'h7FFF_FFFF_FFFF_FFFF;
  localparam logic [63:0] SAT_NEG  = 64'h8000_0000_0000_0000;
  localparam logic [63:0] FRAC_OVF = 64'h4000_0000_0000_0000;

  typedef enum logic [3:0] {
    OP_PROD_ACC_S    = 4'h0,
    OP_PROD_ACC_U    = 4'h1,
    OP_PROD_ACCUM_S  = 4'h2,
    OP_PROD_ACCUM_U  = 4'h3,
    OP_PROD_DEDUCT_S = 4'h4,
    OP_PROD_DEDUCT_U = 4'h5,
    OP_PROD_GPR      = 4'h6,
    OP_QUOT_S        = 4'h7,
    OP_QUOT_U        = 4'h8,
    OP_MOVE_UPPER    = 4'h9,
    OP_MOVE_BOTTOM   = 4'hA,
    OP_DSP_MACQ      = 4'hB,
    OP_DSP_MACQ_SAT  = 4'hC,
    OP_DSP_MULQ      = 4'hD,
    OP_ACC_SHIFT     = 4'hE,
    OP_ACC_EXTRACT   = 4'hF
  } mdu_op_t;

  typedef struct packed {
    mdu_op_t    op;
    logic [1:0] acc;
    logic [4:0] dest;
    logic [5:0] sh;
  } mdu_tag_t;
endpackage
`default_nettype wire

// ==== include/mdu_mul_if.sv ====
// Operand and product stream between issue logic and the Booth array
`timescale 1ns/1ps
`default_nettype none
interface mdu_mul_if;
  logic              in_valid;
  logic [31:0]       in_a;
  logic [31:0]       in_b;
  logic              in_sgn;
  mdu_pkg::mdu_tag_t in_tag;
  logic              out_valid;
  logic [63:0]       out_prod;
  mdu_pkg::mdu_tag_t out_tag;
  modport issue (output in_valid, in_a, in_b, in_sgn, in_tag,
                 input  out_valid, out_prod, out_tag);
  modport array (input  in_valid, in_a, in_b, in_sgn, in_tag,
                 output out_valid, out_prod, out_tag);
endinterface
`default_nettype wire

// ==== hdl/mdu_booth.sv ====
// Two-pass 32x16 radix-4 Booth multiplier, two pipeline stages
`timescale 1ns/1ps
`default_nettype none
module mdu_booth (
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  rstn,
  // Operand and product stream
  mdu_mul_if.array   mif
);
  logic signed [32:0] a_ext;
  logic signed [32:0] b_ext;
  logic signed [16:0] b_lo;
  logic signed [49:0] lo_pp;
  logic signed [49:0] hi_pp;
  logic signed [65:0] full;
  logic signed [65:0] ref_p;
  logic        [63:0] ref_lo;
  logic               v1_r;
  logic signed [32:0] a1_r;
  logic signed [16:0] bh1_r;
  logic signed [49:0] lo1_r;
  mdu_pkg::mdu_tag_t  tag1_r;

  // One 33x17 signed pass; the 17th bit carries sign or zero extension
  function automatic logic signed [49:0] booth(input logic signed [32:0] a,
                                               input logic signed [16:0] b);
    logic signed [49:0] acc;
    logic signed [49:0] pp;
    logic        [18:0] bx;
    logic        [2:0]  g;
    acc = '0;
    bx  = {b[16], b, 1'b0};
    for (int i = 0; i < 9; i++) begin
      g = bx[2*i +: 3];
      case (g)
        3'h1, 3'h2: pp = 50'(a);
        3'h3:       pp = 50'(a) <<< 1;
        3'h4:       pp = -(50'(a) <<< 1);
        3'h5, 3'h6: pp = -50'(a);
        default:    pp = '0;
      endcase
      acc = acc + (pp <<< (2*i));
    end
    return acc;
  endfunction

  assign a_ext  = {mif.in_sgn & mif.in_a[31], mif.in_a};
  assign b_ext  = {mif.in_sgn & mif.in_b[31], mif.in_b};
  assign b_lo   = {1'b0, mif.in_b[15:0]};
  assign lo_pp  = booth(a_ext, b_lo);
  assign hi_pp  = booth(a1_r, bh1_r);
  assign full   = (66'(hi_pp) <<< 16) + 66'(lo1_r);
  assign ref_p  = a_ext * b_ext;
  assign ref_lo = ref_p[63:0];

  // First pass: low slice of source_b
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      v1_r   <= 1'b0;
      a1_r   <= '0;
      bh1_r  <= '0;
      lo1_r  <= '0;
      tag1_r <= '0;
    end else begin
      v1_r   <= mif.in_valid;
      a1_r   <= a_ext;
      bh1_r  <= b_ext[32:16];
      lo1_r  <= lo_pp;
      tag1_r <= mif.in_tag;
    end
  end

  // Second pass: high slice, combined with the first
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mif.out_valid <= 1'b0;
      mif.out_prod  <= '0;
      mif.out_tag   <= '0;
    end else begin
      mif.out_valid <= v1_r;
      mif.out_prod  <= full[63:0];
      mif.out_tag   <= tag1_r;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  booth_prod_a: assert property (
    mif.in_valid |-> ##2 (mif.out_valid && mif.out_prod == $past(ref_lo, 2)))
    else $error("Booth product wrong or late");
endmodule
`default_nettype wire

// ==== hdl/mdu_top.sv ====
// Multiply/divide unit: multiply pipeline, iterative divider, accumulators
`timescale 1ns/1ps
`default_nettype none
module mdu_top (
  // Clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RSTN,
  // Issue from the integer pipe
  input  wire logic        REQ_VALID,
  input  wire logic [3:0]  REQ_OP,
  input  wire logic [1:0]  REQ_ACC,
  input  wire logic [4:0]  REQ_DEST,
  input  wire logic [31:0] REQ_SRC_A,
  input  wire logic [31:0] REQ_SRC_B,
  output logic             MD_READY,
  output logic             MD_STALL,
  // General register write-back
  output logic             RES_VALID,
  output logic [4:0]       RES_DEST,
  output logic [31:0]      RES_DATA,
  // Status
  output logic             DIV_BUSY
);
  // ******************************************************************
  // Decode
  // ******************************************************************
  mdu_pkg::mdu_op_t  op;
  logic              is_div;
  logic              take;
  logic              take_pipe;
  logic              take_div;
  logic              req_sgn;

  function automatic logic is_sgn(input mdu_pkg::mdu_op_t o);
    return o inside {mdu_pkg::OP_PROD_ACC_S, mdu_pkg::OP_PROD_ACCUM_S,
                     mdu_pkg::OP_PROD_DEDUCT_S, mdu_pkg::OP_PROD_GPR,
                     mdu_pkg::OP_QUOT_S, mdu_pkg::OP_DSP_MACQ,
                     mdu_pkg::OP_DSP_MACQ_SAT, mdu_pkg::OP_DSP_MULQ};
  endfunction

  function automatic logic to_gpr(input mdu_pkg::mdu_op_t o);
    return o inside {mdu_pkg::OP_PROD_GPR, mdu_pkg::OP_MOVE_UPPER,
                     mdu_pkg::OP_MOVE_BOTTOM, mdu_pkg::OP_ACC_EXTRACT};
  endfunction

  function automatic logic writes_acc(input mdu_pkg::mdu_op_t o);
    return !to_gpr(o) && !(o inside {mdu_pkg::OP_QUOT_S, mdu_pkg::OP_QUOT_U});
  endfunction

  assign op        = mdu_pkg::mdu_op_t'(REQ_OP);
  assign is_div    = op inside {mdu_pkg::OP_QUOT_S, mdu_pkg::OP_QUOT_U};
  assign req_sgn   = is_sgn(op);
  assign take      = REQ_VALID & MD_READY;
  assign take_pipe = take & !is_div;
  assign take_div  = take & is_div;

  // ******************************************************************
  // Issue stage and multiplier array
  // ******************************************************************
  mdu_mul_if mif ();

  // Only a running divide holds issue; the multiply stream never waits
  assign MD_READY = !DIV_BUSY;
  assign MD_STALL = REQ_VALID & DIV_BUSY;

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      mif.in_valid <= 1'b0;
      mif.in_a     <= '0;
      mif.in_b     <= '0;
      mif.in_sgn   <= 1'b0;
      mif.in_tag   <= '0;
    end else begin
      mif.in_valid <= take_pipe;
      mif.in_a     <= REQ_SRC_A;
      mif.in_b     <= REQ_SRC_B;
      mif.in_sgn   <= req_sgn;
      mif.in_tag   <= {op, REQ_ACC, REQ_DEST, REQ_SRC_B[5:0]};
    end
  end

  mdu_booth u_booth (
    .clk  (SYS_CLK),
    .rstn (RSTN),
    .mif  (mif.array)
  );

  // ******************************************************************
  // Accumulate stage
  // ******************************************************************
  logic [63:0] acc_r [mdu_pkg::ACC_NUM];
  logic [63:0] acc_old;
  logic [63:0] acc_new;
  logic [63:0] extr;
  logic [31:0] gpr_val;
  logic        acc_we;
  logic        s4_v_r;
  logic [4:0]  s4_dest_r;
  logic [31:0] s4_data_r;
  logic        res_v_r;
  logic [4:0]  res_dest_r;
  logic [31:0] res_data_r;

  // Fractional products are doubled; only the saturating form clamps
  function automatic logic [63:0] acc_next(input mdu_pkg::mdu_op_t o,
                                           input logic [63:0] old,
                                           input logic [63:0] p,
                                           input logic [5:0]  sh);
    logic [63:0] fq;
    logic [63:0] fs;
    logic [64:0] s;
    logic [5:0]  amt;
    fq  = {p[62:0], 1'b0};
    fs  = (p == mdu_pkg::FRAC_OVF) ? mdu_pkg::SAT_POS : fq;
    s   = {old[63], old} + {fs[63], fs};
    amt = sh[5] ? (~sh + 6'h01) : sh;
    case (o)
      mdu_pkg::OP_PROD_ACC_S,
      mdu_pkg::OP_PROD_ACC_U:    return p;
      mdu_pkg::OP_PROD_ACCUM_S,
      mdu_pkg::OP_PROD_ACCUM_U:  return old + p;
      mdu_pkg::OP_PROD_DEDUCT_S,
      mdu_pkg::OP_PROD_DEDUCT_U: return old - p;
      mdu_pkg::OP_DSP_MACQ:      return old + fq;
      mdu_pkg::OP_DSP_MACQ_SAT:
        return (s[64] != s[63]) ? (s[64] ? mdu_pkg::SAT_NEG : mdu_pkg::SAT_POS)
                                : s[63:0];
      mdu_pkg::OP_DSP_MULQ:      return fq;
      // Positive amount shifts right, negative shifts left
      mdu_pkg::OP_ACC_SHIFT:     return sh[5] ? (old << amt) : (old >> amt);
      default:                   return old;
    endcase
  endfunction

  assign acc_old = acc_r[mif.out_tag.acc];
  assign acc_new = acc_next(mif.out_tag.op, acc_old, mif.out_prod, mif.out_tag.sh);
  assign acc_we  = mif.out_valid & writes_acc(mif.out_tag.op);
  assign extr    = acc_old >> mif.out_tag.sh[4:0];
  assign gpr_val = (mif.out_tag.op == mdu_pkg::OP_PROD_GPR)    ? mif.out_prod[31:0] :
                   (mif.out_tag.op == mdu_pkg::OP_MOVE_UPPER)  ? acc_old[63:32] :
                   (mif.out_tag.op == mdu_pkg::OP_MOVE_BOTTOM) ? acc_old[31:0] :
                   extr[31:0];

  // ******************************************************************
  // Divider
  // ******************************************************************
  logic        div_busy_r;
  logic [5:0]  div_cnt_r;
  logic [5:0]  div_iter_r;
  logic [32:0] div_rem_r;
  logic [31:0] div_quo_r;
  logic [31:0] div_dvd_r;
  logic [31:0] div_dvs_r;
  logic [31:0] div_mag_r;
  logic        div_negq_r;
  logic        div_negr_r;
  logic [1:0]  div_acc_r;
  logic [1:0]  div_cls;
  logic [31:0] mag_a;
  logic [31:0] mag_b;
  logic [32:0] rem_sh;
  logic [32:0] rem_dif;
  logic [31:0] quo_fix;
  logic [31:0] rem_fix;
  logic        div_wr;

  // Width class from the sign extension of source_a: 0=8, 1=16, 2=24, 3=32 bits
  function automatic logic [1:0] div_class(input logic [31:0] a, input logic sgn);
    if (sgn) begin
      if (&a[31:7] || ~|a[31:7])
        return 2'h0;
      if (&a[31:15] || ~|a[31:15])
        return 2'h1;
      if (&a[31:23] || ~|a[31:23])
        return 2'h2;
      return 2'h3;
    end
    if (~|a[31:8])
      return 2'h0;
    if (~|a[31:16])
      return 2'h1;
    if (~|a[31:24])
      return 2'h2;
    return 2'h3;
  endfunction

  function automatic logic [5:0] div_skip(input logic [1:0] c);
    case (c)
      2'h0:    return mdu_pkg::DIV_SKIP8;
      2'h1:    return mdu_pkg::DIV_SKIP16;
      2'h2:    return mdu_pkg::DIV_SKIP24;
      default: return mdu_pkg::DIV_SKIP32;
    endcase
  endfunction

  function automatic logic [5:0] div_lat(input logic [1:0] c, input logic sgn);
    case (c)
      2'h0:    return sgn ? mdu_pkg::DIV_LAT8_S  : mdu_pkg::DIV_LAT8_U;
      2'h1:    return sgn ? mdu_pkg::DIV_LAT16_S : mdu_pkg::DIV_LAT16_U;
      2'h2:    return sgn ? mdu_pkg::DIV_LAT24_S : mdu_pkg::DIV_LAT24_U;
      default: return sgn ? mdu_pkg::DIV_LAT32_S : mdu_pkg::DIV_LAT32_U;
    endcase
  endfunction

  assign div_cls = div_class(REQ_SRC_A, req_sgn);
  assign mag_a   = (req_sgn & REQ_SRC_A[31]) ? (~REQ_SRC_A + 32'h1) : REQ_SRC_A;
  assign mag_b   = (req_sgn & REQ_SRC_B[31]) ? (~REQ_SRC_B + 32'h1) : REQ_SRC_B;
  assign rem_sh  = {div_rem_r[31:0], div_dvd_r[31]};
  assign rem_dif = rem_sh - {1'b0, div_dvs_r};
  assign quo_fix = div_negq_r ? (~div_quo_r + 32'h1) : div_quo_r;
  assign rem_fix = div_negr_r ? (~div_rem_r[31:0] + 32'h1) : div_rem_r[31:0];
  // The wait after the last bit pads every divide to its fixed latency
  assign div_wr  = div_busy_r & (div_cnt_r == 6'h01);

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      div_busy_r <= 1'b0;
      div_cnt_r  <= '0;
      div_iter_r <= '0;
      div_rem_r  <= '0;
      div_quo_r  <= '0;
      div_dvd_r  <= '0;
      div_dvs_r  <= '0;
      div_mag_r  <= '0;
      div_negq_r <= 1'b0;
      div_negr_r <= 1'b0;
      div_acc_r  <= '0;
    end else if (take_div) begin
      div_busy_r <= 1'b1;
      div_cnt_r  <= div_lat(div_cls, req_sgn) - 6'h01;
      div_iter_r <= mdu_pkg::DIV_ITER_FULL - div_skip(div_cls);
      div_dvd_r  <= mag_a << div_skip(div_cls);
      div_rem_r  <= '0;
      div_quo_r  <= '0;
      div_dvs_r  <= mag_b;
      div_mag_r  <= mag_a;
      div_negq_r <= req_sgn & (REQ_SRC_A[31] ^ REQ_SRC_B[31]);
      div_negr_r <= req_sgn & REQ_SRC_A[31];
      div_acc_r  <= REQ_ACC;
    end else if (div_busy_r) begin
      div_cnt_r <= div_cnt_r - 6'h01;
      if (div_wr)
        div_busy_r <= 1'b0;
      if (div_iter_r != 6'h00) begin
        div_iter_r <= div_iter_r - 6'h01;
        div_rem_r  <= rem_dif[32] ? rem_sh : rem_dif;
        div_quo_r  <= {div_quo_r[30:0], !rem_dif[32]};
        div_dvd_r  <= {div_dvd_r[30:0], 1'b0};
      end
    end
  end

  // ******************************************************************
  // Accumulator pairs and write-back
  // ******************************************************************
  // Issue order keeps the two writers apart; the divider wins regardless
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < mdu_pkg::ACC_NUM; i++)
        acc_r[i] <= mdu_pkg::ACC_RST;
    end else if (div_wr) begin
      acc_r[div_acc_r] <= {rem_fix, quo_fix};
    end else if (acc_we) begin
      acc_r[mif.out_tag.acc] <= acc_new;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      s4_v_r     <= 1'b0;
      s4_dest_r  <= '0;
      s4_data_r  <= '0;
      res_v_r    <= 1'b0;
      res_dest_r <= '0;
      res_data_r <= '0;
    end else begin
      s4_v_r     <= mif.out_valid & to_gpr(mif.out_tag.op);
      s4_dest_r  <= mif.out_tag.dest;
      s4_data_r  <= gpr_val;
      res_v_r    <= s4_v_r;
      res_dest_r <= s4_dest_r;
      res_data_r <= s4_data_r;
    end
  end

  assign RES_VALID = res_v_r;
  assign RES_DEST  = res_dest_r;
  assign RES_DATA  = res_data_r;
  assign DIV_BUSY  = div_busy_r;

  // ******************************************************************
  // Checks
  // ******************************************************************
  logic [31:0] ref_lo;
  assign ref_lo = REQ_SRC_A * REQ_SRC_B;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);

  sequence gpr_pair_s;
    (take_pipe && to_gpr(op)) ##1 (take_pipe && to_gpr(op));
  endsequence
  sequence div_hold_s;
    ##1 (!MD_READY) [*8] ##1 (!MD_READY) [*3];
  endsequence

  pipe_advance_a: assert property (
    take_pipe |-> ##3 mif.out_valid)
    else $error("Multiply stream did not advance");
  back_to_back_a: assert property (
    gpr_pair_s |-> ##4 RES_VALID ##1 RES_VALID)
    else $error("Back to back issues not both answered");
  acc_write_a: assert property (
    take_pipe && writes_acc(op) |-> ##3 (acc_we && mif.out_tag.acc == $past(REQ_ACC, 3)))
    else $error("Accumulator write missing or misdirected");
  gpr_mul_a: assert property (
    take_pipe && op == mdu_pkg::OP_PROD_GPR |-> ##5 (RES_VALID &&
      RES_DEST == $past(REQ_DEST, 5) && RES_DATA == $past(ref_lo, 5)))
    else $error("Register product wrong or late");
  div_result_a: assert property (
    div_wr && div_dvs_r != 32'h0 |-> div_rem_r[31:0] < div_dvs_r &&
      64'(div_quo_r) * 64'(div_dvs_r) + 64'(div_rem_r[31:0]) == 64'(div_mag_r))
    else $error("Quotient and remainder inconsistent");
  skip8_a: assert property (
    take_div && div_cls == 2'h0 |=> div_iter_r == mdu_pkg::DIV_ITER_FULL - mdu_pkg::DIV_SKIP8)
    else $error("Short dividend skip wrong");
  skip16_a: assert property (
    take_div && div_cls == 2'h1 |=> div_iter_r == mdu_pkg::DIV_ITER_FULL - mdu_pkg::DIV_SKIP16)
    else $error("Half dividend skip wrong");
  div8u_time_a: assert property (
    take_div && div_cls == 2'h0 && !req_sgn |-> div_hold_s ##1 MD_READY)
    else $error("Short unsigned divide latency wrong");
  div32s_time_a: assert property (
    take_div && div_cls == 2'h3 && req_sgn |-> ##37 !MD_READY ##1 MD_READY)
    else $error("Full signed divide latency wrong");
  div_stall_a: assert property (
    take_div |-> div_hold_s)
    else $error("Issue not held during divide");
  move_upper_a: assert property (
    take_pipe && op == mdu_pkg::OP_MOVE_UPPER |-> ##5 (RES_VALID && RES_DEST == $past(REQ_DEST, 5)))
    else $error("Move from upper not answered");
  accum_a: assert property (
    acc_we && mif.out_tag.op == mdu_pkg::OP_PROD_ACCUM_U && !div_wr |=>
      acc_r[$past(mif.out_tag.acc)] == $past(acc_old) + $past(mif.out_prod))
    else $error("Accumulate sum wrong");
  deduct_a: assert property (
    acc_we && mif.out_tag.op == mdu_pkg::OP_PROD_DEDUCT_U && !div_wr |=>
      acc_r[$past(mif.out_tag.acc)] == $past(acc_old) - $past(mif.out_prod))
    else $error("Deduct difference wrong");
endmodule
`default_nettype wire

// ==== dv/mdu_issue_model.sv ====
// Integer issue pipe model: queues requests and holds each one until taken
`timescale 1ns/1ps
`default_nettype none
module mdu_issue_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Requests from the bench
  input  wire logic        go,
  input  wire logic [74:0] req,
  // Issue port of the unit
  output logic             req_valid,
  output logic [74:0]      req_bus,
  input  wire logic        md_ready,
  input  wire logic        md_stall
);
  logic [74:0] q[$];

  // Idle fields toggle so a stale request never looks like a live one
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q.delete();
      req_valid <= 1'b0;
      req_bus   <= 75'h0;
    end else begin
      if (req_valid && md_ready && !md_stall) void'(q.pop_front());
      if (go) q.push_back(req);
      req_valid <= (q.size() != 0);
      req_bus   <= (q.size() != 0) ? q[0] : ~req_bus;
    end
  end
endmodule
`default_nettype wire

// ==== dv/mdu_top_tb.sv ====
// Self-checking bench of the multiply/divide unit
`timescale 1ns/1ps
`default_nettype none
module mdu_top_tb;
  logic        SYS_CLK, RSTN, go, req_valid, MD_READY, MD_STALL, RES_VALID, DIV_BUSY;
  logic [3:0]  REQ_OP;
  logic [1:0]  REQ_ACC;
  logic [4:0]  REQ_DEST, RES_DEST, dcnt;
  logic [31:0] REQ_SRC_A, REQ_SRC_B, RES_DATA;
  logic [74:0] req, req_bus;
  logic [36:0] eq[$];
  logic [36:0] e;
  logic [63:0] acc[4];
  int          tq[$];
  int          cyc, dt, stalls, exp_lat, n_mismatch, samples_checked;
  bit          dpend;

  initial begin
    SYS_CLK = 1'b0;
    forever #4 SYS_CLK = ~SYS_CLK;
  end

  assign {REQ_OP, REQ_ACC, REQ_DEST, REQ_SRC_A, REQ_SRC_B} = req_bus;

  mdu_issue_model u_mdu_issue_model (.clk(SYS_CLK), .rstn(RSTN), .go(go), .req(req),
    .req_valid(req_valid), .req_bus(req_bus), .md_ready(MD_READY), .md_stall(MD_STALL));
  mdu_top u_mdu_top (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .REQ_VALID(req_valid), .REQ_OP(REQ_OP),
    .REQ_ACC(REQ_ACC), .REQ_DEST(REQ_DEST), .REQ_SRC_A(REQ_SRC_A), .REQ_SRC_B(REQ_SRC_B),
    .MD_READY(MD_READY), .MD_STALL(MD_STALL), .RES_VALID(RES_VALID), .RES_DEST(RES_DEST),
    .RES_DATA(RES_DATA), .DIV_BUSY(DIV_BUSY));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic send(input logic [3:0] op, input logic [1:0] sel,
                      input logic [31:0] a, input logic [31:0] b, input logic [31:0] exp);
    @(posedge SYS_CLK);
    go  <= 1'b1;
    req <= {op, sel, dcnt, a, b};
    if (op inside {4'h6, 4'h9, 4'hA, 4'hF}) eq.push_back({dcnt, exp});
    dcnt <= dcnt + 5'h01;
  endtask

  task automatic drain(input string name);
    @(posedge SYS_CLK);
    go <= 1'b0;
    for (int i = 0; i < 200 && (eq.size() != 0 || dpend || req_valid); i++) @(negedge SYS_CLK);
    // A result still owed when the limit runs out is a failure, not a skip
    if (eq.size() != 0 || dpend) chk(32'h1, 32'h0);
    $display("%s done", name);
  endtask

  // ****************************************
  // Result monitor: latency, data and stalls
  // ****************************************
  always @(negedge SYS_CLK) begin
    if (RSTN) begin
      if (req_valid && MD_READY && REQ_OP inside {4'h6, 4'h9, 4'hA, 4'hF}) tq.push_back(cyc);
      if (RES_VALID && eq.size() != 0 && tq.size() != 0) begin
        e = eq.pop_front();
        chk(cyc - tq.pop_front(), 32'h5);
        chk({27'h0, RES_DEST}, {27'h0, e[36:32]});
        chk(RES_DATA, e[31:0]);
      end else if (RES_VALID) chk(32'h1, 32'h0);
      if (req_valid && MD_READY && REQ_OP inside {4'h7, 4'h8}) begin
        dt = cyc;
        dpend = 1'b1;
        stalls = 0;
      end else if (dpend) begin
        if (MD_STALL) stalls++;
        if (!DIV_BUSY) begin
          chk(cyc - dt, exp_lat);
          chk(stalls, exp_lat - 1);
          dpend = 1'b0;
        end
      end
      cyc++;
    end
  end

  task automatic t_mul();
    send(4'h6, 2'h0, 32'hFFFF_FFF3, 32'h0001_2345, 32'hFFFF_FFF3 * 32'h0001_2345);
    send(4'h6, 2'h1, 32'h7654_3210, 32'h0000_8001, 32'h7654_3210 * 32'h0000_8001);
    send(4'h6, 2'h2, 32'h8123_4567, 32'hF00D_0003, 32'h8123_4567 * 32'hF00D_0003);
    drain("t_mul");
  endtask

  // Ops alternate signed and unsigned; operands stay positive so both agree
  task automatic t_acc();
    for (int k = 0; k < 4; k++) begin
      acc[k] = {32'h0, 32'h0ABC_0000 + 32'(k)} * 64'h1_0003;
      send(4'(k % 2), 2'(k), 32'h0ABC_0000 + 32'(k), 32'h0001_0003, 32'h0);
    end
    for (int k = 0; k < 4; k++) begin
      acc[k] = acc[k] + 64'(7 * (k + 1));
      send(4'(2 + k % 2), 2'(k), 32'h7, 32'(k + 1), 32'h0);
    end
    for (int k = 0; k < 4; k++) begin
      acc[k] = acc[k] - 64'(k) * 64'h7FFF_0000;
      send(4'(4 + k % 2), 2'(k), 32'(k), 32'h7FFF_0000, 32'h0);
    end
    for (int k = 0; k < 4; k++) begin
      send(4'hA, 2'(k), 32'h0, 32'h0, acc[k][31:0]);
      send(4'h9, 2'(k), 32'h0, 32'h0, acc[k][63:32]);
    end
    drain("t_acc");
  endtask

  task automatic t_div();
    logic [31:0] dv[8] = '{32'h64, 32'h9C40, 32'h00AB_CDEF, 32'h9ABC_DEF0,
                          32'hFFFF_FF9C, 32'hFFFF_8AD0, 32'hFFC4_3211, 32'hEDCB_A988};
    int          lat[8] = '{12, 20, 28, 36, 14, 22, 30, 38};
    logic [31:0] b, q, r;
    for (int i = 0; i < 8; i++) begin
      b = (i < 4) ? 32'h7 : 32'hFFFF_FFF9;
      // Kept apart: one unsigned branch would turn the signed divide unsigned
      if (i < 4) begin
        q = dv[i] / b;
        r = dv[i] % b;
      end else begin
        q = $signed(dv[i]) / $signed(b);
        r = $signed(dv[i]) % $signed(b);
      end
      exp_lat = lat[i];
      send((i < 4) ? 4'h8 : 4'h7, 2'h1, dv[i], b, 32'h0);
      send(4'hA, 2'h1, 32'h0, 32'h0, q);
      send(4'h9, 2'h1, 32'h0, 32'h0, r);
      drain("t_div");
    end
  endtask

  task automatic t_dsp();
    send(4'hD, 2'h3, 32'h3, 32'h5, 32'h0);
    send(4'hB, 2'h3, 32'h2, 32'hFFFF_FFFC, 32'h0);
    send(4'hC, 2'h3, 32'h1, 32'h1, 32'h0);
    send(4'hF, 2'h3, 32'h0, 32'h0, 32'h10);
    send(4'hE, 2'h3, 32'h0, 32'h1, 32'h0);
    send(4'hF, 2'h3, 32'h0, 32'h2, 32'h2);
    // Minus one squared plus a positive sum must clamp to the top value
    send(4'hC, 2'h3, 32'h8000_0000, 32'h8000_0000, 32'h0);
    send(4'h9, 2'h3, 32'h0, 32'h0, 32'h7FFF_FFFF);
    send(4'hA, 2'h3, 32'h0, 32'h0, 32'hFFFF_FFFF);
    send(4'hE, 2'h3, 32'h0, 32'h3F, 32'h0);
    send(4'hA, 2'h3, 32'h0, 32'h0, 32'hFFFF_FFFE);
    drain("t_dsp");
  endtask

  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge SYS_CLK);
    n_mismatch++;
    results();
  end

  initial begin
    RSTN = 1'b0;
    go = 1'b0;
    req = 75'h0;
    dcnt = 5'h00;
    repeat (16) @(posedge SYS_CLK);
    RSTN <= 1'b1;
    t_mul();
    t_acc();
    t_div();
    t_dsp();
    results();
  end
endmodule
`default_nettype wire
